// ### hdl/csm_top.sv
// CAS signaling register bank and per-direction channel monitor with APB access
//
// Contract
// - First register low nibble holds alarm bits.
// - Sixteen signaling registers at consecutive addresses.
// - Register n+1 holds channels n and n+15.
// - Monitor one transmit and one receive channel.
// - Transmit select is bits 4:0 of select register.
// - Receive select is bits 4:0 of select register.
// - Transmit monitor byte readable at its address.
// - Receive monitor byte readable at its address.
// - Transmit monitor bit 7 is first sent.
// - Receive monitor bit 7 is first received.
// - Loopback and AIS bits stored, used outside.
// - Line reset and elastic bits stored, used outside.
// - Reads give receive data unless readback set.
// - Receive signaling loaded on multiframe boundaries.
// - Insert enable shifts buffer into slot 16.
`timescale 1ns/1ps
`include "csm_params.svh"
module csm_top
    import csm_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Transmit stream in, one bit per enable
    input  wire logic              txBitEn,
    input  wire logic              txBitIn,
    input  wire logic              txFrameSync,
    input  wire logic              txMfSync,
    // Transmit stream out, after signaling insertion
    output logic                   txBitOut,
    output logic                   txBitOutEn,
    // Receive stream in, one bit per enable
    input  wire logic              rxBitEn,
    input  wire logic              rxBitIn,
    input  wire logic              rxFrameSync,
    input  wire logic              rxMfSync,
    // Control levels for neighbouring blocks
    output logic                   remoteLoopbackCtrl,
    output logic                   localLoopbackCtrl,
    output logic                   lineAisGenEnable,
    output logic                   lineInterfaceResetCtrl,
    output logic                   rxElasticAlign,
    output logic                   rxElasticReset
);

    csm_state_t st;
    csm_state_t next_st;

    // Bus decode terms
    logic [7:0] regIdx;
    logic       setupPhase;
    logic       writeHit;
    logic [3:0] sigSlot;
    logic       isSig;

    // Stream position terms
    logic [7:0] txPos;
    logic [3:0] txFrmNow;
    logic [7:0] rxPos;
    logic [3:0] rxFrmNow;
    logic       txIsSigSlot;
    logic       rxIsSigSlot;
    logic       txLineBit;

    // Register index is the word address
    assign regIdx     = 8'(paddr[ADDR_W-1:2]);
    assign setupPhase = psel && !penable;
    assign writeHit   = psel && penable && pwrite && pstrb[0];
    assign isSig      = (regIdx >= `CSM_IDX_SIG_LO) && (regIdx <= `CSM_IDX_SIG_HI);
    assign sigSlot    = 4'(regIdx - `CSM_IDX_SIG_LO);

    // Zero wait state slave
    assign pready  = 1'b1;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;

    // Bit position of the bit carried in this enable
    assign txPos    = txFrameSync ? 8'h00 : 8'(st.txBitCnt + 8'h01);
    assign rxPos    = rxFrameSync ? 8'h00 : 8'(st.rxBitCnt + 8'h01);
    assign txFrmNow = txMfSync ? 4'h0 : (txFrameSync ? 4'(st.txFrm + 4'h1) : st.txFrm);
    assign rxFrmNow = rxMfSync ? 4'h0 : (rxFrameSync ? 4'(st.rxFrm + 4'h1) : st.rxFrm);
    assign txIsSigSlot = (txPos[7:3] == `CSM_SIG_SLOT);
    assign rxIsSigSlot = (rxPos[7:3] == `CSM_SIG_SLOT);

    // Bit actually sent to the line, slot 16 replaced when inserting
    assign txLineBit = (txIsSigSlot && st.sigCtrl[`CSM_BIT_INS])
                       ? st.txShift[`CSM_SIG_BITS-1] : txBitIn;

    // Control bits handed to neighbouring logic
    assign remoteLoopbackCtrl     = st.txSel[`CSM_BIT_RMT_LOOP];
    assign localLoopbackCtrl      = st.txSel[`CSM_BIT_LOC_LOOP];
    assign lineAisGenEnable       = st.txSel[`CSM_BIT_AIS];
    assign lineInterfaceResetCtrl = st.rxSel[`CSM_BIT_LINE_RST];
    assign rxElasticAlign         = st.rxSel[`CSM_BIT_ES_ALIGN];
    assign rxElasticReset         = st.rxSel[`CSM_BIT_ES_RST];

    // Stream outputs come straight from state
    assign txBitOut   = st.txOut;
    assign txBitOutEn = st.txOutEn;

    // Next state of the whole block
    always_comb begin
        next_st = st;
        next_st.txOutEn = 1'b0;

        // Read data captured in the setup phase, held through access
        if (setupPhase) begin
            next_st.prdata  = 32'h0000_0000;
            next_st.pslverr = 1'b0;
            if (isSig) begin
                if (st.sigCtrl[`CSM_BIT_RDBK]) begin
                    next_st.prdata[7:0] = st.txSig[sigSlot];
                end else begin
                    next_st.prdata[7:0] = st.rxSig[sigSlot];
                end
            end else begin
                case (regIdx)
                    `CSM_IDX_TX_SEL:   next_st.prdata[7:0] = st.txSel;
                    `CSM_IDX_RX_SEL:   next_st.prdata[7:0] = st.rxSel;
                    `CSM_IDX_TX_MON:   next_st.prdata[7:0] = st.txMon;
                    `CSM_IDX_RX_MON:   next_st.prdata[7:0] = st.rxMon;
                    `CSM_IDX_SIG_CTRL: next_st.prdata[7:0] = st.sigCtrl;
                    default:           next_st.pslverr = 1'b1;
                endcase
            end
        end

        // Register writes take effect in the access phase
        if (writeHit) begin
            if (isSig) begin
                next_st.txSig[sigSlot] = pwdata[7:0];
            end else begin
                case (regIdx)
                    `CSM_IDX_TX_SEL:   next_st.txSel = pwdata[7:0];
                    `CSM_IDX_RX_SEL:   next_st.rxSel = pwdata[7:0];
                    `CSM_IDX_SIG_CTRL: next_st.sigCtrl = pwdata[7:0];
                    default:           next_st.sigCtrl = st.sigCtrl;
                endcase
            end
        end

        // Transmit side: position, insertion and monitor
        if (txBitEn) begin
            next_st.txBitCnt = txPos;
            next_st.txFrm    = txFrmNow;
            next_st.txOut    = txLineBit;
            next_st.txOutEn  = 1'b1;
            // Multiframe boundary loads the whole buffer, first register leading
            if (txMfSync) begin
                for (int i = 0; i < `CSM_NUM_SIG; i++) begin
                    next_st.txShift[`CSM_SIG_BITS-1-8*i -: 8] = st.txSig[i];
                end
            end else if (txIsSigSlot) begin
                next_st.txShift = {st.txShift[`CSM_SIG_BITS-2:0], 1'b0};
            end
            // Collect the outgoing byte, first bit ends in bit 7
            next_st.txMonShift = {st.txMonShift[5:0], txLineBit};
            if (txPos[2:0] == `CSM_LAST_BIT &&
                txPos[7:3] == st.txSel[`CSM_SEL_MSB:0]) begin
                next_st.txMon = {st.txMonShift, txLineBit};
            end
        end

        // Receive side: position, slot 16 capture and monitor
        if (rxBitEn) begin
            next_st.rxBitCnt = rxPos;
            next_st.rxFrm    = rxFrmNow;
            // Completed multiframe becomes visible to the host
            if (rxMfSync) begin
                next_st.rxSig = st.rxShadow;
            end
            if (rxIsSigSlot) begin
                next_st.rxByte = {st.rxByte[6:0], rxBitIn};
                if (rxPos[2:0] == `CSM_LAST_BIT) begin
                    next_st.rxShadow[rxFrmNow] = {st.rxByte[6:0], rxBitIn};
                end
            end
            // Collect the incoming byte, first bit ends in bit 7
            next_st.rxMonShift = {st.rxMonShift[5:0], rxBitIn};
            if (rxPos[2:0] == `CSM_LAST_BIT &&
                rxPos[7:3] == st.rxSel[`CSM_SEL_MSB:0]) begin
                next_st.rxMon = {st.rxMonShift, rxBitIn};
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st.txSel      <= `CSM_BYTE_RST;
            st.rxSel      <= `CSM_BYTE_RST;
            st.sigCtrl    <= `CSM_BYTE_RST;
            st.txSig      <= '0;
            st.rxSig      <= '0;
            st.rxShadow   <= '0;
            st.txShift    <= '0;
            st.txBitCnt   <= `CSM_CNT_RST;
            st.txFrm      <= `CSM_FRM_RST;
            st.rxBitCnt   <= `CSM_CNT_RST;
            st.rxFrm      <= `CSM_FRM_RST;
            st.rxByte     <= `CSM_BYTE_RST;
            st.txMonShift <= 7'h00;
            st.rxMonShift <= 7'h00;
            st.txMon      <= `CSM_BYTE_RST;
            st.rxMon      <= `CSM_BYTE_RST;
            st.txOut      <= 1'b0;
            st.txOutEn    <= 1'b0;
            st.prdata     <= 32'h0000_0000;
            st.pslverr    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### inc/csm_params.svh
// Register indices, field positions, reset values and counts for the CAS signaling monitor
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
`define CSM_IDX_TX_SEL   8'h14
`define CSM_IDX_RX_SEL   8'h15
`define CSM_IDX_TX_MON   8'h22
`define CSM_IDX_RX_MON   8'h2a
`define CSM_IDX_SIG_LO   8'h30
`define CSM_IDX_SIG_HI   8'h3f
`define CSM_IDX_SIG_CTRL 8'h40
`define CSM_SEL_MSB      4
`define CSM_BIT_RMT_LOOP 7
`define CSM_BIT_LOC_LOOP 6
`define CSM_BIT_AIS      5
`define CSM_BIT_LINE_RST 7
`define CSM_BIT_ES_ALIGN 6
`define CSM_BIT_ES_RST   5
`define CSM_BIT_RDBK     5
`define CSM_BIT_INS      3
`define CSM_SIG_SLOT     5'd16
`define CSM_NUM_SIG      16
`define CSM_SIG_BITS     128
`define CSM_LAST_BIT     3'h7
`define CSM_BYTE_RST     8'h00
`define CSM_CNT_RST      8'hff
`define CSM_FRM_RST      4'hf
`endif

// ### inc/csm_pkg.sv
// Types for the CAS signaling monitor
package csm_pkg;
    `include "csm_params.svh"

    typedef logic [7:0] csm_byte_t;
    typedef logic [`CSM_NUM_SIG-1:0][7:0] csm_bank_t;

    typedef struct packed {
        csm_byte_t                 txSel;
        csm_byte_t                 rxSel;
        csm_byte_t                 sigCtrl;
        csm_bank_t                 txSig;
        csm_bank_t                 rxSig;
        csm_bank_t                 rxShadow;
        logic [`CSM_SIG_BITS-1:0]  txShift;
        csm_byte_t                 txBitCnt;
        logic [3:0]                txFrm;
        csm_byte_t                 rxBitCnt;
        logic [3:0]                rxFrm;
        csm_byte_t                 rxByte;
        logic [6:0]                txMonShift;
        logic [6:0]                rxMonShift;
        csm_byte_t                 txMon;
        csm_byte_t                 rxMon;
        logic                      txOut;
        logic                      txOutEn;
        logic [31:0]               prdata;
        logic                      pslverr;
    } csm_state_t;
endpackage

// ### sim/csm_chk.sv
// Concurrent checks on the register port and stream echo of the signaling block
`timescale 1ns/1ps
module csm_chk #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Stream and control levels
    input wire logic              txBitEn,
    input wire logic              txBitOutEn,
    input wire logic              remoteLoopbackCtrl,
    input wire logic              localLoopbackCtrl,
    input wire logic              lineAisGenEnable,
    input wire logic              lineInterfaceResetCtrl,
    input wire logic              rxElasticAlign,
    input wire logic              rxElasticReset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Setup phases and strobed access phases
    sequence setupAt(logic [7:0] idx);
        psel && !penable && paddr[ADDR_W-1:2] == idx;
    endsequence
    sequence wrSel(logic [7:0] idx, logic s);
        setupAt(idx) && pwrite ##1 penable && pstrb[0] == s;
    endsequence
    chk_tx_ctrl_wr: assert property (wrSel(8'h14, 1'b1) |=>
        {remoteLoopbackCtrl, localLoopbackCtrl, lineAisGenEnable} == $past(pwdata[7:5])) else $error("tx ctrl");
    chk_rx_ctrl_wr: assert property (wrSel(8'h15, 1'b1) |=>
        {lineInterfaceResetCtrl, rxElasticAlign, rxElasticReset} == $past(pwdata[7:5])) else $error("rx ctrl");
    chk_strb_block: assert property (wrSel(8'h14, 1'b0) |=> $stable(remoteLoopbackCtrl)) else $error("strobe");
    chk_ctrl_hold: assert property (!(psel && penable && pwrite) |=>
        $stable({remoteLoopbackCtrl, lineAisGenEnable, rxElasticReset})) else $error("ctrl moved");
    chk_err_unmapped: assert property (setupAt(8'h00) |=> pslverr && prdata == 0) else $error("unmapped");
    chk_err_mapped: assert property (setupAt(8'h22) or setupAt(8'h2a) |=>
        !pslverr && prdata[31:8] == 24'h0) else $error("monitor read");
    chk_sig_mapped: assert property (setupAt(8'h30) or setupAt(8'h3f) |=> !pslverr) else $error("sig");
    chk_zero_wait: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0) else $error("access");
    chk_echo_on: assert property (txBitEn |=> txBitOutEn) else $error("no echo");
    chk_echo_off: assert property (!txBitEn |=> !txBitOutEn) else $error("extra echo");
endmodule
bind csm_top csm_chk #(.ADDR_W(ADDR_W)) chk (.*);

// ### sim/csm_host.sv
// APB host model issuing register transfers
`timescale 1ns/1ps
module csm_host (
    // Clock and answer
    input  wire logic [31:0] prdata,
    input  wire logic        clock,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    int hangs = 0;
    // Idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // Setup, access held until pready, then one idle cycle
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [7:0] r, output logic e);
        int n;
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h0, d, s};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hangs += int'(n >= 16);
        r = prdata[7:0];
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clock);
    endtask
endmodule

// ### sim/csm_top_tb_top.sv
// Self-checking bench for the signaling bank and channel monitors
`timescale 1ns/1ps
`define CHK(g, x) begin testsRun++; if ((g) !== (x)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
module csm_top_tb_top;
    import csm_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        txBitEn, txBitIn, txFrameSync, txMfSync, txBitOut, txBitOutEn;
    logic        rxBitEn, rxBitIn, rxFrameSync, rxMfSync, remoteLoopbackCtrl, localLoopbackCtrl;
    logic        lineAisGenEnable, lineInterfaceResetCtrl, rxElasticAlign, rxElasticReset;
    csm_byte_t   r, x;
    logic [4351:0] cap;
    int          miscompares = 0, testsRun = 0, opos = 0;
    csm_top DUT (.*);
    csm_host host (.*);
    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Capture of outgoing bits
    always @(posedge clock) if (txBitOutEn === 1'b1) begin
        cap[opos] <= txBitOut;
        opos <= opos + 1;
    end
    // Stream byte patterns and host transmit values
    function automatic csm_byte_t pat(int f, int s);
        return 8'(f * 16 + s) ^ 8'h5a;
    endfunction
    function automatic csm_byte_t tv(int i);
        return (i == 0) ? 8'h0b : 8'(i * 37 + 1);
    endfunction
    function automatic csm_byte_t grab(int p);
        csm_byte_t g;
        for (int k = 0; k < 8; k++) g = {g[6:0], cap[p + k]};
        return g;
    endfunction
    // Select and control registers
    task automatic testRegs();
        host.xfer(0, 10'h054, 8'h00, 4'h1, r, e);
        `CHK(r, 8'h00)
        host.xfer(1, 10'h050, 8'ha6, 4'h1, r, e);
        host.xfer(1, 10'h054, 8'hef, 4'h1, r, e);
        host.xfer(1, 10'h050, 8'h00, 4'h0, r, e);
        host.xfer(0, 10'h050, 8'h00, 4'h1, r, e);
        `CHK(r, 8'ha6)
        `CHK({remoteLoopbackCtrl, localLoopbackCtrl, lineAisGenEnable}, 3'b101)
        `CHK({lineInterfaceResetCtrl, rxElasticAlign, rxElasticReset}, 3'b111)
        host.xfer(0, 10'h000, 8'h00, 4'h1, r, e);
        `CHK(e, 1'b1)
        host.xfer(1, 10'h050, 8'h06, 4'h1, r, e);
        host.xfer(1, 10'h054, 8'h0f, 4'h1, r, e);
        host.xfer(1, 10'h088, 8'hff, 4'h1, r, e);
        $display("test regs done");
    endtask
    // Seventeen frames both ways with signaling insertion
    task automatic testStream();
        for (int i = 0; i < 16; i++) host.xfer(1, 10'(192 + 4 * i), tv(i), 4'h1, r, e);
        host.xfer(1, 10'h100, 8'h08, 4'h1, r, e);
        opos = 0;
        for (int b = 0; b < 4352; b++) begin
            @(posedge clock);
            x = pat((b / 256) % 16, (b / 8) % 32);
            {txBitEn, txFrameSync, txMfSync, txBitIn} <= {1'b1, b % 256 == 0, b % 4096 == 0, ~x[7 - b % 8]};
            {rxBitEn, rxFrameSync, rxMfSync, rxBitIn} <= {1'b1, b % 256 == 0, b % 4096 == 0, x[7 - b % 8]};
        end
        @(posedge clock);
        {txBitEn, rxBitEn} <= 2'b00;
        repeat (2) @(posedge clock);
        for (int f = 0; f < 16; f++) `CHK(grab(f * 256 + 128), tv(f))
        `CHK(grab(3 * 256 + 48), ~pat(3, 6))
        host.xfer(0, 10'h088, 8'h00, 4'h1, r, e);
        `CHK(r, ~pat(0, 6))
        host.xfer(0, 10'h0a8, 8'h00, 4'h1, r, e);
        `CHK(r, pat(0, 15))
        for (int i = 0; i < 16; i++) begin
            host.xfer(0, 10'(192 + 4 * i), 8'h00, 4'h1, r, e);
            `CHK(r, pat(i, 16))
        end
        host.xfer(1, 10'h100, 8'h28, 4'h1, r, e);
        host.xfer(0, 10'h100, 8'h00, 4'h1, r, e);
        `CHK(r, 8'h28)
        for (int i = 0; i < 16; i++) begin
            host.xfer(0, 10'(192 + 4 * i), 8'h00, 4'h1, r, e);
            `CHK(r, tv(i))
        end
        $display("test stream done");
    endtask
    // Verdict
    task automatic closeOut();
        miscompares += host.hangs;
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, txBitEn, txBitIn, txFrameSync, txMfSync, rxBitEn, rxBitIn, rxFrameSync, rxMfSync} = '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        testRegs();
        testStream();
        closeOut();
    end
endmodule
